// File: core/mpd_pkg.sv
// package with widths, mode codes and timing constants of the motor pwm unit
package mpd_pkg;
	localparam int CNT_W = 16;
	localparam int DT_W = 8;
	localparam int NUM_CH = 3;
	localparam int NUM_TRIG = 6;
	localparam int PRE_W = 4;
	// motor channel mode codes
	localparam logic [1:0] MCH_2CH_SYM = 2'h0;
	localparam logic [1:0] MCH_1CH_ASYM = 2'h1;
	localparam logic [1:0] MCH_1CH_SYM = 2'h2;
	// adc trigger mode codes
	localparam logic [1:0] ATM_OFF = 2'h0;
	localparam logic [1:0] ATM_UP = 2'h1;
	localparam logic [1:0] ATM_DOWN = 2'h2;
	localparam logic [1:0] ATM_BOTH = 2'h3;
	// dead-time prescale: last prescaler count for x4 and x16
	localparam logic [PRE_W-1:0] PRE_LAST_X4 = 4'h3;
	localparam logic [PRE_W-1:0] PRE_LAST_X16 = 4'hf;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [DT_W-1:0] DT_ZERO = 8'h00;
	localparam logic [DT_W-1:0] DT_ONE = 8'h01;
	localparam logic [PRE_W-1:0] PRE_ZERO = 4'h0;
	localparam logic [PRE_W-1:0] PRE_ONE = 4'h1;
	typedef enum logic [2:0] {
		MPD_IDLE = 3'b001,
		MPD_UP = 3'b010,
		MPD_DOWN = 3'b100
	} mpd_cnt_state_type;
endpackage

// File: core/mpd_deadtime.sv
// dead-time mask for one output of a complementary pair
`timescale 1ns/1ps
`default_nettype none
module mpd_deadtime (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic raw_i,
	input wire logic dt_on_i,
	input wire logic prescale_sel_i,
	input wire logic [mpd_pkg::DT_W-1:0] deadtime_value_i,
	output logic out_o
);
	import mpd_pkg::*;

	logic raw_q;
	logic busy;
	logic [DT_W-1:0] dt_cnt;
	logic [PRE_W-1:0] pre_cnt;
	logic out_q;
	logic next_raw_q;
	logic next_busy;
	logic [DT_W-1:0] next_dt_cnt;
	logic [PRE_W-1:0] next_pre_cnt;
	logic next_out_q;
	logic [PRE_W-1:0] pre_last;

	// mask starts on the rising edge of the raw level; a falling raw level cancels it,
	// so a pulse shorter than the dead-time never reaches the pin
	always_comb begin
		pre_last = prescale_sel_i ? PRE_LAST_X16 : PRE_LAST_X4;
		next_raw_q = raw_i;
		next_busy = busy;
		next_dt_cnt = dt_cnt;
		next_pre_cnt = pre_cnt;
		next_out_q = out_q;
		if (!dt_on_i || deadtime_value_i == DT_ZERO) begin
			next_busy = 1'b0;
			next_out_q = raw_i;
		end else if (!raw_i) begin
			next_busy = 1'b0;
			next_out_q = 1'b0;
		end else if (!raw_q) begin
			next_busy = 1'b1;
			next_dt_cnt = DT_ZERO;
			next_pre_cnt = PRE_ZERO;
			next_out_q = 1'b0;
		end else if (busy) begin
			if (pre_cnt == pre_last) begin
				next_pre_cnt = PRE_ZERO;
				if (dt_cnt + DT_ONE == deadtime_value_i) begin
					next_busy = 1'b0;
					next_out_q = 1'b1;
				end else begin
					next_dt_cnt = dt_cnt + DT_ONE;
				end
			end else begin
				next_pre_cnt = pre_cnt + PRE_ONE;
			end
		end else begin
			next_out_q = 1'b1;
		end
	end

	// registers only, on every rising clock edge
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			raw_q <= 1'b0;
			busy <= 1'b0;
			dt_cnt <= DT_ZERO;
			pre_cnt <= PRE_ZERO;
			out_q <= 1'b0;
		end else begin
			raw_q <= next_raw_q;
			busy <= next_busy;
			dt_cnt <= next_dt_cnt;
			pre_cnt <= next_pre_cnt;
			out_q <= next_out_q;
		end
	end

	assign out_o = out_q;
endmodule
`default_nettype wire

// File: core/mpd_motor_pwm.sv
// three-channel motor pwm generator with dead-time, adc triggers and event pulses
// Functional notes
// - 1ch asymmetric: high side active on up-count H-duty match, default on down-count L-duty match.
// - 1ch modes without dead-time: low side is the inverse of the high side once running.
// - before start, high and low outputs are held low.
// - on start in 1ch asymmetric mode, low side goes active, then follows inverse of high.
// - 1ch symmetric uses high duty only, matched up to clear and down to set.
// - normal_mode_select 0 with motor_channel_mode 10 selects 1ch symmetric.
// - dead-time is applied only in motor mode, never in normal mode.
// - with dead-time enabled, a dead interval precedes each output going active.
// - prescale 0: dead-time is value times four clock periods.
// - prescale 1: dead-time is value times sixteen clock periods.
// - duty match masks output and starts counter; mask ends at programmed value.
// - no dead-time in 2ch symmetric; separation comes from each channel duty.
// - symmetric modes compare duty in both up and down half of the period.
// - six adc trigger values, each pulses a trigger at its counter value.
// - each timing event, period and high duty matches, raises an event request.
// - normal_mode_select 0 with motor_channel_mode 00 selects 2ch symmetric.
// - up/down counting makes a period twice the up-only period.
// - trigger mode 00 disables, 01 triggers on up-count match.
`timescale 1ns/1ps
`default_nettype none
module mpd_motor_pwm (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic run_start_bit_i,
	input wire logic normal_mode_select_i,
	input wire logic updown_i,
	input wire logic [1:0] motor_channel_mode_i,
	input wire logic deadtime_enable_i,
	input wire logic deadtime_prescale_sel_i,
	input wire logic [mpd_pkg::DT_W-1:0] deadtime_value_i,
	input wire logic [mpd_pkg::CNT_W-1:0] period_i,
	input wire logic [mpd_pkg::NUM_CH*mpd_pkg::CNT_W-1:0] duty_h_i,
	input wire logic [mpd_pkg::NUM_CH*mpd_pkg::CNT_W-1:0] duty_l_i,
	input wire logic [mpd_pkg::NUM_TRIG*mpd_pkg::CNT_W-1:0] trig_value_i,
	input wire logic [mpd_pkg::NUM_TRIG*2-1:0] adc_trigger_mode_i,
	output logic [mpd_pkg::NUM_CH-1:0] pwm_h_o,
	output logic [mpd_pkg::NUM_CH-1:0] pwm_l_o,
	output logic [mpd_pkg::NUM_TRIG-1:0] adc_trig_o,
	output logic period_evt_o,
	output logic [mpd_pkg::NUM_CH-1:0] duty_evt_o,
	output logic [mpd_pkg::CNT_W-1:0] count_o,
	output logic count_down_o
);
	import mpd_pkg::*;

	mpd_cnt_state_type state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [NUM_CH-1:0] raw_h, next_raw_h;
	logic [NUM_CH-1:0] raw_l, next_raw_l;
	logic [NUM_TRIG-1:0] trig, next_trig;
	logic [NUM_CH-1:0] duty_evt, next_duty_evt;
	logic period_evt, next_period_evt;
	logic [NUM_CH-1:0] dt_h, dt_l;
	logic [NUM_CH-1:0] h_q, l_q, next_h_q, next_l_q;
	logic motor_mode, one_ch, dt_on;
	logic going_down;
	logic period_end;
	logic count_down, next_count_down;

	// slice of a packed vector of counter-wide words
	function automatic logic [CNT_W-1:0] word_at(input logic [NUM_TRIG*CNT_W-1:0] v, input int idx);
		word_at = v[idx*CNT_W +: CNT_W];
	endfunction

	assign motor_mode = !normal_mode_select_i;
	assign one_ch = motor_mode && (motor_channel_mode_i == MCH_1CH_SYM
		|| motor_channel_mode_i == MCH_1CH_ASYM);
	assign dt_on = deadtime_enable_i && one_ch;
	assign going_down = (state == MPD_DOWN);

	// period counter: up-only wraps at period, up/down turns round, doubling the period
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		period_end = 1'b0;
		unique case (state)
			MPD_IDLE: begin
				next_cnt = CNT_ZERO;
				if (run_start_bit_i) begin
					next_state = MPD_UP;
				end
			end
			MPD_UP: begin
				if ((updown_i || motor_mode) && cnt >= period_i) begin
					next_state = MPD_DOWN;
					next_cnt = cnt - CNT_ONE;
				end else if (!(updown_i || motor_mode) && cnt + CNT_ONE >= period_i) begin
					// up-only wraps one step early so its period is exactly half the up/down one
					next_cnt = CNT_ZERO;
					period_end = 1'b1;
				end else begin
					next_cnt = cnt + CNT_ONE;
				end
			end
			MPD_DOWN: begin
				if (cnt == CNT_ZERO) begin
					next_state = MPD_UP;
					next_cnt = CNT_ONE;
					period_end = 1'b1;
				end else begin
					next_cnt = cnt - CNT_ONE;
				end
			end
			default: begin
				next_state = MPD_IDLE;
				next_cnt = CNT_ZERO;
			end
		endcase
		if (!run_start_bit_i) begin
			next_state = MPD_IDLE;
			next_cnt = CNT_ZERO;
		end
		// direction kept in its own flop so the output comes straight from a register
		next_count_down = (next_state == MPD_DOWN);
	end

	// raw waveform per channel from duty matches, before dead-time
	always_comb begin
		logic [CNT_W-1:0] dh;
		logic [CNT_W-1:0] dl;
		dh = CNT_ZERO;
		dl = CNT_ZERO;
		next_raw_h = raw_h;
		next_raw_l = raw_l;
		next_duty_evt = '0;
		for (int c = 0; c < NUM_CH; c++) begin
			dh = word_at({{(NUM_TRIG-NUM_CH)*CNT_W{1'b0}}, duty_h_i}, c);
			dl = word_at({{(NUM_TRIG-NUM_CH)*CNT_W{1'b0}}, duty_l_i}, c);
			if (state == MPD_IDLE) begin
				next_raw_h[c] = 1'b0;
				next_raw_l[c] = 1'b0;
			end else if (motor_mode) begin
				// level = counter below duty, so the compare acts in both halves
				next_raw_h[c] = (cnt < dh) || (dh >= period_i);
				if (motor_channel_mode_i == MCH_1CH_ASYM) begin
					if (!going_down && cnt == dh) begin
						next_raw_h[c] = 1'b1;
					end else if (going_down && cnt == dl) begin
						next_raw_h[c] = 1'b0;
					end else begin
						next_raw_h[c] = raw_h[c];
					end
				end
				if (one_ch) begin
					next_raw_l[c] = !next_raw_h[c];
				end else begin
					next_raw_l[c] = (cnt < dl) || (dl >= period_i);
				end
			end else begin
				next_raw_h[c] = cnt < dh;
				next_raw_l[c] = !(cnt < dh);
			end
			next_duty_evt[c] = (state != MPD_IDLE) && (cnt == dh);
		end
	end

	// adc triggers and period event pulses
	always_comb begin
		logic [1:0] m;
		logic hit;
		m = ATM_OFF;
		hit = 1'b0;
		next_period_evt = period_end;
		for (int t = 0; t < NUM_TRIG; t++) begin
			m = adc_trigger_mode_i[t*2 +: 2];
			hit = (state != MPD_IDLE) && (cnt == word_at(trig_value_i, t));
			unique case (m)
				ATM_OFF: next_trig[t] = 1'b0;
				ATM_UP: next_trig[t] = hit && !going_down;
				ATM_DOWN: next_trig[t] = hit && going_down;
				ATM_BOTH: next_trig[t] = hit;
			endcase
		end
	end

	// dead-time per output; bypassed when not in a 1-channel motor mode
	for (genvar g = 0; g < NUM_CH; g++) begin : g_dt
		mpd_deadtime u_dt_h (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.raw_i(raw_h[g]),
			.dt_on_i(dt_on),
			.prescale_sel_i(deadtime_prescale_sel_i),
			.deadtime_value_i(deadtime_value_i),
			.out_o(dt_h[g])
		);
		mpd_deadtime u_dt_l (
			.core_clk_i(core_clk_i),
			.sys_rst_i(sys_rst_i),
			.raw_i(raw_l[g]),
			.dt_on_i(dt_on),
			.prescale_sel_i(deadtime_prescale_sel_i),
			.deadtime_value_i(deadtime_value_i),
			.out_o(dt_l[g])
		);
	end

	// output stage: force low while stopped
	always_comb begin
		next_h_q = (state == MPD_IDLE) ? '0 : dt_h;
		next_l_q = (state == MPD_IDLE) ? '0 : dt_l;
	end

	// registers of the counter, waveforms, pulses and outputs
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= MPD_IDLE;
			cnt <= CNT_ZERO;
			raw_h <= '0;
			raw_l <= '0;
			trig <= '0;
			duty_evt <= '0;
			period_evt <= 1'b0;
			count_down <= 1'b0;
			h_q <= '0;
			l_q <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			raw_h <= next_raw_h;
			raw_l <= next_raw_l;
			trig <= next_trig;
			duty_evt <= next_duty_evt;
			period_evt <= next_period_evt;
			count_down <= next_count_down;
			h_q <= next_h_q;
			l_q <= next_l_q;
		end
	end

	assign pwm_h_o = h_q;
	assign pwm_l_o = l_q;
	assign adc_trig_o = trig;
	assign duty_evt_o = duty_evt;
	assign period_evt_o = period_evt;
	assign count_o = cnt;
	assign count_down_o = count_down;
endmodule
`default_nettype wire

// File: sim/mpd_motor_pwm_assertions.sv
// port assertions of the motor pwm unit
`timescale 1ns/1ps
`default_nettype none
module mpd_motor_pwm_chk import mpd_pkg::*; (
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic run_start_bit_i,
	input wire logic normal_mode_select_i,
	input wire logic [1:0] motor_channel_mode_i,
	input wire logic deadtime_enable_i,
	input wire logic [DT_W-1:0] deadtime_value_i,
	input wire logic [CNT_W-1:0] period_i,
	input wire logic [NUM_CH*CNT_W-1:0] duty_h_i,
	input wire logic [NUM_CH*CNT_W-1:0] duty_l_i,
	input wire logic [NUM_TRIG*2-1:0] adc_trigger_mode_i,
	input wire logic [NUM_CH-1:0] pwm_h_o,
	input wire logic [NUM_CH-1:0] pwm_l_o,
	input wire logic [NUM_CH-1:0] duty_evt_o,
	input wire logic [NUM_TRIG-1:0] adc_trig_o,
	input wire logic [CNT_W-1:0] count_o,
	input wire logic count_down_o,
	input wire logic period_evt_o
);
	logic [2:0] run_cnt;
	logic ok;
	logic dt_on;
	// cycles since start, saturating; checks wait until the output pipeline has filled
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			run_cnt <= 3'h0;
		else if (!run_start_bit_i)
			run_cnt <= 3'h0;
		else if (!ok)
			run_cnt <= run_cnt + 3'h1;
	end
	// dead-time only counts in the single channel motor modes with a nonzero value
	assign ok = run_cnt == 3'h7;
	assign dt_on = !normal_mode_select_i && motor_channel_mode_i != MCH_2CH_SYM && deadtime_enable_i
		&& deadtime_value_i != DT_ZERO;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_IDLE_LOW: assert property ((!run_start_bit_i) [*4] |-> pwm_h_o == 3'h0 && pwm_l_o == 3'h0)
		else $error("outputs active while stopped");
	AST_LOW_INV: assert property (ok && !normal_mode_select_i && motor_channel_mode_i != MCH_2CH_SYM
		&& !dt_on |-> pwm_l_o == ~pwm_h_o) else $error("low side not inverse of high side");
	AST_SYM_CMP: assert property (ok && !normal_mode_select_i && motor_channel_mode_i != MCH_1CH_ASYM
		&& !dt_on |-> pwm_h_o[0] == ($past(count_o, 3) < duty_h_i[15:0] || duty_h_i[15:0] >= period_i))
		else $error("high side does not follow duty compare");
	AST_LOW_2CH: assert property (ok && !normal_mode_select_i && motor_channel_mode_i == MCH_2CH_SYM
		|-> pwm_l_o[0] == ($past(count_o, 3) < duty_l_i[15:0])) else $error("2ch low side off its duty");
	AST_TURN: assert property (ok && !normal_mode_select_i && count_o == period_i
		|=> count_o == period_i - CNT_ONE) else $error("counter did not turn down at period");
	AST_DUTY_EVT: assert property (ok && duty_evt_o[0]
		|-> count_o == duty_h_i[15:0] || $past(count_o) == duty_h_i[15:0]) else $error("duty event off match");
	AST_TRIG_OFF: assert property ((adc_trigger_mode_i[1:0] == ATM_OFF) [*2] |-> !adc_trig_o[0])
		else $error("disabled trigger fired");
	AST_DT_GAP: assert property (ok && dt_on && $rose(pwm_h_o[0]) |-> !$past(pwm_l_o[0]))
		else $error("no dead interval before high side");
	// in motor mode the period ends where the counter turns from zero back up to one
	AST_PERIOD_EVT: assert property (ok && !normal_mode_select_i
		|-> period_evt_o == (count_o == CNT_ONE && $past(count_o) == CNT_ZERO)) else $error("period event off turn");
	AST_DIR: assert property (ok && !normal_mode_select_i
		|-> count_down_o == (count_o < $past(count_o))) else $error("count direction flag wrong");
endmodule
bind mpd_motor_pwm mpd_motor_pwm_chk i_mpd_motor_pwm_chk (.core_clk_i, .sys_rst_i, .run_start_bit_i,
	.normal_mode_select_i, .motor_channel_mode_i, .deadtime_enable_i, .deadtime_value_i, .period_i,
	.duty_h_i, .duty_l_i, .adc_trigger_mode_i, .pwm_h_o, .pwm_l_o, .duty_evt_o, .adc_trig_o, .count_o,
	.count_down_o, .period_evt_o);
`default_nettype wire

// File: sim/mpd_bridge_model.sv
// gate driver and adc model: counts conversions started and clock cycles with any leg shorted
`timescale 1ns/1ps
`default_nettype none
module mpd_bridge_model import mpd_pkg::*; (
	input wire logic core_clk_i,
	input wire logic clr_i,
	input wire logic [NUM_CH-1:0] gate_h_i,
	input wire logic [NUM_CH-1:0] gate_l_i,
	input wire logic [NUM_TRIG-1:0] conv_i,
	output logic [NUM_TRIG*8-1:0] conv_cnt_o,
	output logic [7:0] short_cnt_o
);
	// each trigger pulse starts one conversion; both switches of a leg on shorts the supply
	always_ff @(posedge core_clk_i) begin
		for (int t = 0; t < NUM_TRIG; t++) begin
			if (clr_i)
				conv_cnt_o[t*8+:8] <= 8'h00;
			else if (conv_i[t])
				conv_cnt_o[t*8+:8] <= conv_cnt_o[t*8+:8] + 8'h01;
		end
		if (clr_i)
			short_cnt_o <= 8'h00;
		else if ((gate_h_i & gate_l_i) != 3'h0)
			short_cnt_o <= short_cnt_o + 8'h01;
	end
endmodule
`default_nettype wire

// File: sim/tb_mpd_motor_pwm.sv
// self-checking bench of the motor pwm unit
`timescale 1ns/1ps
`default_nettype none
module tb_mpd_motor_pwm;
	import mpd_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic run_start_bit_i = 1'b0;
	logic normal_mode_select_i = 1'b0;
	logic updown_i = 1'b1;
	logic [1:0] motor_channel_mode_i = 2'h0;
	logic deadtime_enable_i = 1'b0;
	logic deadtime_prescale_sel_i = 1'b0;
	logic [DT_W-1:0] deadtime_value_i = 8'h00;
	logic [CNT_W-1:0] period_i = 16'h0004;
	logic [NUM_CH*CNT_W-1:0] duty_h_i = 48'h0;
	logic [NUM_CH*CNT_W-1:0] duty_l_i = 48'h0;
	logic [NUM_TRIG*CNT_W-1:0] trig_value_i = 96'h0;
	logic [NUM_TRIG*2-1:0] adc_trigger_mode_i = 12'h000;
	logic [NUM_CH-1:0] pwm_h_o, pwm_l_o, duty_evt_o;
	logic [NUM_TRIG-1:0] adc_trig_o;
	logic period_evt_o, count_down_o, clr = 1'b1;
	logic [CNT_W-1:0] count_o;
	logic [NUM_TRIG*8-1:0] conv_cnt;
	logic [7:0] short_cnt;
	int err_total = 0;
	int tests_run = 0;
	int cyc = 0;
	mpd_motor_pwm i_mpd_motor_pwm (.core_clk_i, .sys_rst_i, .run_start_bit_i, .normal_mode_select_i, .updown_i,
		.motor_channel_mode_i, .deadtime_enable_i, .deadtime_prescale_sel_i, .deadtime_value_i, .period_i,
		.duty_h_i, .duty_l_i, .trig_value_i, .adc_trigger_mode_i, .pwm_h_o, .pwm_l_o, .adc_trig_o,
		.period_evt_o, .duty_evt_o, .count_o, .count_down_o);
	mpd_bridge_model i_mpd_bridge_model (.core_clk_i, .clr_i(clr), .gate_h_i(pwm_h_o), .gate_l_i(pwm_l_o),
		.conv_i(adc_trig_o), .conv_cnt_o(conv_cnt), .short_cnt_o(short_cnt));
	initial forever #20 core_clk_i = ~core_clk_i;
	// hang guard; the whole run needs about 1500 cycles
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	task automatic results();
		if (err_total == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// configure all channels alike, only while the counter is stopped
	task automatic setup(input logic n, input logic [1:0] m, input logic e, input logic p, input logic [7:0] v,
		input logic [15:0] pr, input logic [15:0] h, input logic [15:0] l);
		@(posedge core_clk_i);
		normal_mode_select_i <= n;
		motor_channel_mode_i <= m;
		deadtime_enable_i <= e;
		deadtime_prescale_sel_i <= p;
		deadtime_value_i <= v;
		period_i <= pr;
		duty_h_i <= {3{h}};
		duty_l_i <= {3{l}};
	endtask
	// settle past the first period, then count active cycles of channel 0 over one whole up/down period
	task automatic measure(output logic [15:0] nh, output logic [15:0] nl);
		nh = 16'h0000;
		nl = 16'h0000;
		@(posedge core_clk_i);
		run_start_bit_i <= 1'b1;
		repeat (2 * period_i + 10) @(posedge core_clk_i);
		clr <= 1'b0;
		repeat (2 * period_i) begin
			@(negedge core_clk_i);
			nh += pwm_h_o[0];
			nl += pwm_l_o[0];
		end
		@(posedge core_clk_i);
		run_start_bit_i <= 1'b0;
		clr <= 1'b1;
		@(negedge core_clk_i);
	endtask
	task automatic t_idle();
		repeat (4) begin
			@(negedge core_clk_i);
			chk("idle outputs", 16'h0000, {pwm_h_o, pwm_l_o});
		end
	endtask
	task automatic t_sym();
		logic [15:0] nh, nl;
		setup(1'b0, MCH_1CH_SYM, 1'b0, 1'b0, 8'h00, 16'h0004, 16'h0002, 16'h0000);
		measure(nh, nl);
		chk("sym high", 2 * 2 - 1, nh);
		chk("sym low", 2 * 4 - 3, nl);
	endtask
	task automatic t_asym();
		logic [15:0] nh, nl;
		setup(1'b0, MCH_1CH_ASYM, 1'b0, 1'b0, 8'h00, 16'h0006, 16'h0001, 16'h0003);
		measure(nh, nl);
		chk("asym high", (6 - 1 + 1) + (6 - 1 - 3), nh);
		chk("asym low", 12 - 8, nl);
	endtask
	// each side loses the dead interval; too long a dead interval removes the pulse
	task automatic t_dead();
		logic [15:0] nh, nl;
		logic p [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		logic [7:0] v [4] = '{8'h02, 8'h01, 8'h03, 8'h00};
		int dt;
		for (int i = 0; i < 4; i++) begin
			dt = v[i] * (p[i] ? 16 : 4);
			setup(1'b0, MCH_1CH_SYM, 1'b1, p[i], v[i], 16'h0028, 16'h000f, 16'h0000);
			measure(nh, nl);
			chk("dead high", (dt < 29) ? 29 - dt : 0, nh);
			chk("dead low", (dt < 51) ? 51 - dt : 0, nl);
			chk("shoot through", 16'h0000, short_cnt);
		end
	endtask
	// normal mode and 2ch symmetric ignore the dead-time setting
	task automatic t_nodead();
		logic [15:0] nh, nl;
		setup(1'b1, MCH_1CH_SYM, 1'b1, 1'b0, 8'h02, 16'h0028, 16'h000f, 16'h0000);
		measure(nh, nl);
		chk("normal high", 29, nh);
		// up-only counting: the same window holds two whole periods
		setup(1'b1, MCH_1CH_SYM, 1'b1, 1'b0, 8'h02, 16'h0028, 16'h000f, 16'h0000);
		updown_i <= 1'b0;
		measure(nh, nl);
		chk("up-only high", 30, nh);
		chk("up-only low", 50, nl);
		setup(1'b0, MCH_2CH_SYM, 1'b1, 1'b0, 8'h02, 16'h0028, 16'h000f, 16'h000a);
		updown_i <= 1'b1;
		measure(nh, nl);
		chk("2ch high", 29, nh);
		chk("2ch low", 19, nl);
	endtask
	task automatic t_full();
		logic [15:0] nh, nl;
		for (int i = 0; i < 2; i++) begin
			setup(1'b0, MCH_1CH_SYM, 1'b0, 1'b0, 8'h00, 16'h0008, i ? 16'h0000 : 16'h0008, 16'h0000);
			measure(nh, nl);
			chk("full high", i ? 0 : 16, nh);
			chk("full low", i ? 16 : 0, nl);
		end
	endtask
	task automatic t_trig();
		logic [15:0] nh, nl;
		int n [6] = '{0, 1, 1, 2, 1, 1};
		@(posedge core_clk_i);
		trig_value_i <= {6{16'h0005}};
		adc_trigger_mode_i <= {ATM_UP, ATM_UP, ATM_BOTH, ATM_DOWN, ATM_UP, ATM_OFF};
		setup(1'b0, MCH_1CH_SYM, 1'b0, 1'b0, 8'h00, 16'h0014, 16'h0003, 16'h0000);
		measure(nh, nl);
		for (int t = 0; t < NUM_TRIG; t++)
			chk("adc triggers", n[t], conv_cnt[t*8+:8]);
	endtask
	initial begin
		repeat (3) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		t_idle();
		t_sym();
		t_asym();
		t_dead();
		t_nodead();
		t_full();
		t_trig();
		results();
	end
endmodule
`default_nettype wire
